// ---- core/vlt_video_line_timing_config.sv ----
/*
 * Configuration front end of the composite video controller: serially
 * written position, length, control and index base registers, and the line
 * timing, line type, clock control, chroma translate and skip, and direct
 * converter buffering derived from them. Assumes core_clk_i is the video
 * clock and that line index words, chroma tables and run ends come from
 * the surrounding controller.
 */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1 - two-byte msb-first value, stored at deselect
// R2 - opcode 28h stores low 12 start bits
// R3 - normal part starts after fixed 10-clock sync
// R4 - host keeps start below length over eight
// R5 - opcode 29h stores low 12 end bits
// R6 - end position resumes protoline after sync
// R7 - host keeps end above start, within length
// R8 - opcode 2Ah stores 12-bit line length
// R9 - length bit 15 routes control nibble out
// R10 - direct mode buffer length is length+1
// R11 - control word clears at power-up
// R12 - control bit 15 selects direct converter mode
// R13 - bit 14 translates chroma through tables
// R14 - bit 13 picks crystal or multiplied clock
// R15 - enable write starts or restarts lock check
// R16 - host enables multiplier before using converter
// R17 - divider is high bits with 111, plus one
// R18 - nonzero skip count skips chroma runs
// R19 - opcode 2Ch stores index base
// R20 - index byte address is base times four
// R21 - index below base times 32 means protoline
// R22 - direct mode buffer starts at base times two
// R23 - host enables generation last, elsewhere
// R24 - incomplete frame leaves registers unchanged
// R25 - eight video clocks per subcarrier cycle
module vlt_video_line_timing_config (
    input wire logic core_clk_i, // video clock, 100 MHz
    input wire logic rst_i, // asynchronous reset, active high
    input wire logic chip_select_n_i, // serial select, active low
    input wire logic sclk_i, // serial clock
    input wire logic mosi_i, // serial data in
    input wire logic video_generation_on_i, // generation enable from control two
    input wire logic frame_start_i, // pulse, restart index table walk
    input wire logic [19:0] line_index_i, // current line bit-address index
    input wire logic prog_run_done_i, // pulse, one program run ended
    input wire logic [3:0] sram_u_i, // u value fetched from memory
    input wire logic [3:0] sram_v_i, // v value fetched from memory
    input wire logic [15:0] u_table_i, // four u translate entries
    input wire logic [15:0] v_table_i, // four v translate entries
    input wire logic pll_lock_i, // raw multiplier lock indication
    input wire logic [3:0] ctrl_nibble_i, // digital control output
    output logic sync_o, // in fixed sync interval
    output logic line_start_o, // first clock of a line
    output logic line_is_normal_o, // current line is a normal line
    output logic normal_active_o, // inside normal picture part
    output logic [15:0] index_addr_o, // line index byte address, registered
    output logic ctrl_out_to_pins_select_o, // route nibble to pins, registered
    output logic [3:0] general_purpose_pin_o, // pin drive of control nibble
    output logic direct_converter_mode_o, // direct mode, registered
    output logic video_clock_source_select_o, // 1 multiplied clock, registered
    output logic multiplier_osc_enable_o, // oscillator and multiplier on
    output logic lock_check_busy_o, // lock check running
    output logic pll_locked_o, // lock check result, registered
    output logic uv_skip_o, // skip chroma command lines this run
    output logic [3:0] u_o, // u to modulator, registered
    output logic [3:0] v_o, // v to modulator, registered
    output logic dac_tick_o, // converter sample strobe
    output logic [16:0] dac_buf_addr_o // converter buffer address, registered
);
    logic wr_stb; // complete frame received
    logic [7:0] wr_op; // its opcode
    logic [15:0] wr_data; // its value

    vlt_spi_rx u_rx (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .chip_select_n_i(chip_select_n_i),
        .sclk_i(sclk_i),
        .mosi_i(mosi_i),
        .wr_stb_o(wr_stb),
        .wr_op_o(wr_op),
        .wr_data_o(wr_data)
    );

    // configuration registers
    logic [11:0] pic_start_r; // picture_start_position
    logic [11:0] pic_end_r; // picture_end_position
    logic [11:0] line_len_r; // line_length_and_pin_select, length part
    logic pin_sel_r; // line_length_and_pin_select, bit 15
    logic [15:0] ctrl_r; // video_control_one
    logic [15:0] base_r; // line_index_table_base

    // write decode
    wire wr_start_w = wr_stb & (wr_op == vlt_pkg::OP_PIC_START);
    wire wr_end_w = wr_stb & (wr_op == vlt_pkg::OP_PIC_END);
    wire wr_len_w = wr_stb & (wr_op == vlt_pkg::OP_LINE_LEN);
    wire wr_ctrl_w = wr_stb & (wr_op == vlt_pkg::OP_CTRL_ONE);
    wire wr_base_w = wr_stb & (wr_op == vlt_pkg::OP_INDEX_BASE);

    // register file; upper bits of 12-bit fields are dropped
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pic_start_r <= 12'h000;
            pic_end_r <= 12'h000;
            line_len_r <= 12'h000;
            pin_sel_r <= 1'b0;
            ctrl_r <= vlt_pkg::REG_RESET; // R11
            base_r <= vlt_pkg::REG_RESET;
        end else begin
            if (wr_start_w) pic_start_r <= wr_data[vlt_pkg::POS_HI:0]; // R2
            if (wr_end_w) pic_end_r <= wr_data[vlt_pkg::POS_HI:0]; // R5
            if (wr_len_w) begin
                line_len_r <= wr_data[vlt_pkg::POS_HI:0]; // R8
                pin_sel_r <= wr_data[vlt_pkg::LEN_PINSEL]; // R9
            end
            if (wr_ctrl_w) ctrl_r <= wr_data;
            if (wr_base_w) base_r <= wr_data; // R19
        end
    end

    // control field decode
    wire direct_w = ctrl_r[vlt_pkg::CTL_DIRECT]; // R12
    wire translate_w = ctrl_r[vlt_pkg::CTL_TRANSLATE];
    wire [8:0] div_hi_w = ctrl_r[vlt_pkg::CTL_DIV_HI:vlt_pkg::CTL_DIV_LO];
    wire [2:0] skip_runs_w = ctrl_r[vlt_pkg::CTL_SKIP_HI:0];
    wire [11:0] div_max_w = {div_hi_w, vlt_pkg::DIV_LOW_ONES}; // R17

    assign ctrl_out_to_pins_select_o = pin_sel_r; // R9
    assign general_purpose_pin_o = pin_sel_r ? ctrl_nibble_i : 4'h0;
    assign direct_converter_mode_o = direct_w;
    // software must have the multiplier enabled and locked before switching
    assign video_clock_source_select_o = ctrl_r[vlt_pkg::CTL_VIDEO_CLOCK_SOURCE_SELECT]; // R14
    assign multiplier_osc_enable_o = ctrl_r[vlt_pkg::CTL_MULTIPLIER_OSC_ENABLE]; // R15

    // line timing: sync interval plus programmed length per line
    logic [12:0] pos_r; // video clock position within the line
    wire run_w = video_generation_on_i & ~direct_w; // R12
    wire [12:0] line_total_w = vlt_pkg::SYNC_VCLKS + {1'b0, line_len_r}; // R8
    wire line_last_w = (pos_r == (line_total_w - vlt_pkg::POS_STEP));
    wire [12:0] pic_off_w = pos_r - vlt_pkg::SYNC_VCLKS; // R3
    wire [11:0] sc_pos_w = {2'h0, pic_off_w[12:vlt_pkg::SC_SHIFT]}; // R25
    wire in_sync_w = (pos_r < vlt_pkg::SYNC_VCLKS); // R3

    // position counter, held at zero while stopped
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) pos_r <= 13'h0000;
        else if (!run_w || line_last_w) pos_r <= 13'h0000;
        else pos_r <= pos_r + vlt_pkg::POS_STEP;
    end

    assign line_start_o = run_w & (pos_r == 13'h0000);
    assign sync_o = run_w & in_sync_w;

    // line type: index below base scaled to bits means protoline
    wire [19:0] base_bits_w = {6'h00, base_r[vlt_pkg::INDEX_BASE_HI:0]} << vlt_pkg::BITADDR_SHIFT;
    logic line_normal_r; // latched at each line start
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) line_normal_r <= 1'b0;
        else if (line_start_o) line_normal_r <= (line_index_i >= base_bits_w); // R21
    end
    assign line_is_normal_o = line_normal_r;
    // the end bound closes the normal part so the protoline resumes there
    assign normal_active_o = run_w & ~in_sync_w & line_normal_r
        & (sc_pos_w >= pic_start_r) & (sc_pos_w < pic_end_r); // R3 R6

    // index table walk, three bytes per line from base times four
    wire [15:0] index_base_w = {2'h0, base_r[vlt_pkg::INDEX_BASE_HI:0]} << vlt_pkg::INDEX_SHIFT;
    logic [15:0] index_addr_r; // byte address of current line index
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) index_addr_r <= 16'h0000;
        else if (frame_start_i) index_addr_r <= index_base_w; // R20
        else if (run_w && line_last_w) index_addr_r <= index_addr_r + vlt_pkg::INDEX_STEP; // R20
    end
    // the top two bits of base are ignored, keeping the table within the 16-bit byte address
    assign index_addr_o = index_addr_r;

    // lock check: wait for the multiplier to settle, then sample lock
    logic [11:0] lock_cnt_r; // cycles left in the check
    logic locked_r; // check result
    wire lock_kick_w = wr_ctrl_w & wr_data[vlt_pkg::CTL_MULTIPLIER_OSC_ENABLE]; // R15
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_cnt_r <= 12'h000;
            locked_r <= 1'b0;
        end else if (lock_kick_w) begin
            lock_cnt_r <= vlt_pkg::LOCK_WAIT_CYC; // R15
            locked_r <= 1'b0;
        end else if (!multiplier_osc_enable_o) begin
            lock_cnt_r <= 12'h000;
            locked_r <= 1'b0;
        end else if (lock_cnt_r != 12'h000) begin
            lock_cnt_r <= lock_cnt_r - vlt_pkg::CNT12_STEP;
            if (lock_cnt_r == vlt_pkg::CNT12_STEP) locked_r <= pll_lock_i;
        end
    end
    assign lock_check_busy_o = (lock_cnt_r != 12'h000);
    assign pll_locked_o = locked_r;

    // chroma skip: after a fetching run, the next N runs skip u and v
    logic [2:0] skip_left_r; // skipped runs still to come
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) skip_left_r <= 3'h0;
        else if (prog_run_done_i) begin
            if (skip_left_r != 3'h0) skip_left_r <= skip_left_r - vlt_pkg::SKIP_STEP; // R18
            else skip_left_r <= skip_runs_w; // R18
        end
    end
    assign uv_skip_o = (skip_left_r != 3'h0);

    // pick one 4-bit entry of a four-entry table
    function automatic logic [3:0] tbl_pick(input logic [15:0] tbl, input logic [1:0] sel);
        logic [3:0] r;
        case (sel)
            2'h0: r = tbl[3:0];
            2'h1: r = tbl[7:4];
            2'h2: r = tbl[11:8];
            default: r = tbl[15:12];
        endcase
        return r;
    endfunction : tbl_pick

    // chroma output, translated or straight from memory
    wire [3:0] u_nxt = translate_w ? tbl_pick(u_table_i, sram_u_i[1:0]) : sram_u_i; // R13
    wire [3:0] v_nxt = translate_w ? tbl_pick(v_table_i, sram_v_i[1:0]) : sram_v_i; // R13
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            u_o <= 4'h0;
            v_o <= 4'h0;
        end else begin
            u_o <= u_nxt;
            v_o <= v_nxt;
        end
    end

    // direct converter: divided sample strobe walks a length+1 buffer
    logic [11:0] div_cnt_r; // divider count
    logic [11:0] buf_idx_r; // entry within buffer
    wire dac_run_w = video_generation_on_i & direct_w; // R12
    wire tick_w = dac_run_w & (div_cnt_r == div_max_w); // R17
    wire [16:0] dac_start_w = {1'b0, base_r} << vlt_pkg::DAC_SHIFT; // R22
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_r <= 12'h000;
            buf_idx_r <= 12'h000;
        end else if (!dac_run_w) begin
            div_cnt_r <= 12'h000;
            buf_idx_r <= 12'h000;
        end else if (tick_w) begin
            div_cnt_r <= 12'h000; // R17
            if (buf_idx_r == line_len_r) buf_idx_r <= 12'h000; // R10
            else buf_idx_r <= buf_idx_r + vlt_pkg::CNT12_STEP;
        end else begin
            div_cnt_r <= div_cnt_r + vlt_pkg::CNT12_STEP;
        end
    end
    assign dac_tick_o = tick_w;
    // a zero base would place the buffer at address zero, which is illegal
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) dac_buf_addr_o <= 17'h00000;
        else dac_buf_addr_o <= dac_start_w + {5'h00, buf_idx_r}; // R22
    end

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_start_store;
        wr_start_w |=> pic_start_r == $past(wr_data[11:0]);
    endproperty
    a_start_store: assert property (p_start_store) else $error("start not stored"); // R2

    property p_end_store;
        wr_end_w |=> pic_end_r == $past(wr_data[11:0]);
    endproperty
    a_end_store: assert property (p_end_store) else $error("end not stored"); // R5

    property p_len_store;
        wr_len_w |=> line_len_r == $past(wr_data[11:0])
            && ctrl_out_to_pins_select_o == $past(wr_data[15]);
    endproperty
    a_len_store: assert property (p_len_store) else $error("length not stored"); // R8 R9

    sequence s_sync10;
        sync_o [*8] ##1 sync_o ##1 sync_o;
    endsequence
    property p_sync;
        disable iff (rst_i || !run_w)
            (line_start_o && line_len_r != 12'h000) |-> s_sync10 ##1 !sync_o;
    endproperty
    a_sync: assert property (p_sync) else $error("sync interval not ten clocks"); // R3

    property p_direct_quiet;
        direct_w |-> !sync_o && !line_start_o && !normal_active_o;
    endproperty
    a_direct_quiet: assert property (p_direct_quiet) else $error("line timing in direct mode"); // R12

    property p_normal_line;
        line_start_o |=> line_is_normal_o == ($past(line_index_i) >= $past(base_bits_w));
    endproperty
    a_normal_line: assert property (p_normal_line) else $error("line type wrong"); // R21

    property p_index_step;
        (run_w && line_last_w && !frame_start_i) |=> index_addr_o == $past(index_addr_o) + 16'h0003;
    endproperty
    a_index_step: assert property (p_index_step) else $error("index step not three"); // R20

    property p_div_gap;
        (dac_tick_o && !wr_ctrl_w) |=> !dac_tick_o [*7];
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("divider below eight"); // R17

    property p_buf_wrap;
        (dac_tick_o && buf_idx_r == line_len_r) |=> buf_idx_r == 12'h000;
    endproperty
    a_buf_wrap: assert property (p_buf_wrap) else $error("buffer wrap wrong"); // R10

    property p_lock_start;
        lock_kick_w |=> lock_check_busy_o && !pll_locked_o;
    endproperty
    a_lock_start: assert property (p_lock_start) else $error("lock check not started"); // R15

    property p_skip;
        (prog_run_done_i && skip_left_r == 3'h0) |=> skip_left_r == $past(skip_runs_w);
    endproperty
    a_skip: assert property (p_skip) else $error("skip count not loaded"); // R18

    property p_translate;
        (translate_w && $stable(translate_w)) |=> u_o == tbl_pick($past(u_table_i), $past(sram_u_i[1:0]));
    endproperty
    a_translate: assert property (p_translate) else $error("u translate wrong"); // R13
endmodule : vlt_video_line_timing_config
`default_nettype wire

// ---- core/vlt_pkg.sv ----
/*
 * Shared constants of the video line timing configuration block: command
 * opcodes, control word field positions, timing figures and reset values.
 * Assumes a 100 MHz video clock feeding every design file of the block.
 */
package vlt_pkg;
    // write opcodes received over the serial port
    localparam logic [7:0] OP_PIC_START = 8'h28; // picture start position
    localparam logic [7:0] OP_PIC_END = 8'h29; // picture end position
    localparam logic [7:0] OP_LINE_LEN = 8'h2A; // line length and pin select
    localparam logic [7:0] OP_CTRL_ONE = 8'h2B; // first control word
    localparam logic [7:0] OP_INDEX_BASE = 8'h2C; // line index table base

    // serial frame layout: opcode then a two-byte value, msb first
    localparam logic [4:0] FRAME_BITS = 5'h18; // full opcode plus value
    localparam logic [4:0] ONE_BIT = 5'h01; // bit counter step

    // register reset value, every field clears at power-up
    localparam logic [15:0] REG_RESET = 16'h0000;

    // position field width and ignored upper bits
    localparam int POS_HI = 11; // top stored bit of 12-bit fields
    localparam int LEN_PINSEL = 15; // pin routing bit in line length word

    // first control word field positions
    localparam int CTL_DIRECT = 15; // direct converter mode
    localparam int CTL_TRANSLATE = 14; // chroma translate enable
    localparam int CTL_VIDEO_CLOCK_SOURCE_SELECT = 13; // video clock source select
    localparam int CTL_MULTIPLIER_OSC_ENABLE = 12; // multiplier and oscillator enable
    localparam int CTL_DIV_HI = 11; // top of divider high bits
    localparam int CTL_DIV_LO = 3; // bottom of divider high bits
    localparam int CTL_SKIP_HI = 2; // top of chroma skip run count

    // line timing
    localparam logic [12:0] SYNC_VCLKS = 13'h000A; // fixed sync interval
    localparam logic [12:0] POS_STEP = 13'h0001; // one video clock
    localparam int SC_SHIFT = 3; // eight video clocks per subcarrier cycle

    // address forming
    localparam int INDEX_SHIFT = 2; // register to index byte address
    localparam int BITADDR_SHIFT = 5; // register to index bit address
    localparam int DAC_SHIFT = 1; // register to converter buffer address
    localparam logic [15:0] INDEX_STEP = 16'h0003; // bytes per line index
    localparam int INDEX_BASE_HI = 13; // base bits used in normal video mode

    // converter divider low bits are always ones
    localparam logic [2:0] DIV_LOW_ONES = 3'h7;
    localparam logic [11:0] CNT12_STEP = 12'h001; // generic 12-bit step

    // multiplier lock check wait
    localparam int CLK_MHZ = 100; // video clock rate
    localparam int LOCK_WAIT_NS = 10000; // settle time before lock sample
    localparam logic [11:0] LOCK_WAIT_CYC = 12'(LOCK_WAIT_NS * CLK_MHZ / 1000);
    localparam logic [2:0] SKIP_STEP = 3'h1; // skip counter step
endpackage : vlt_pkg

// ---- core/vlt_spi_rx.sv ----
/*
 * Serial write receiver: collects an opcode and a two-byte value, msb
 * first, sampled on rising serial clock edges (mode 0). Assumes the serial
 * pins are synchronous to the core clock and slower than half its rate.
 */
`timescale 1ns/100ps
`default_nettype none
module vlt_spi_rx (
    input wire logic core_clk_i, // video clock
    input wire logic rst_i, // asynchronous reset, active high
    input wire logic chip_select_n_i, // frame select, active low
    input wire logic sclk_i, // serial clock
    input wire logic mosi_i, // serial data in
    output logic wr_stb_o, // one-cycle write pulse
    output logic [7:0] wr_op_o, // received opcode
    output logic [15:0] wr_data_o // received value
);
    logic sclk_q_r; // previous serial clock level
    logic cs_q_r; // previous select level
    logic [4:0] bit_cnt_r; // bits taken in this frame, saturating
    logic [23:0] shift_r; // opcode and value shift register
    logic wr_stb_r; // write pulse
    logic [7:0] op_r; // latched opcode
    logic [15:0] data_r; // latched value

    localparam logic [4:0] FRAME_BITS_L = vlt_pkg::FRAME_BITS;
    wire sclk_rise_w = sclk_i & ~sclk_q_r & ~chip_select_n_i; // sample point
    wire cs_end_w = chip_select_n_i & ~cs_q_r; // frame closed
    wire take_w = sclk_rise_w & (bit_cnt_r != FRAME_BITS_L); // room left

    // edge history
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b1;
        end else begin
            sclk_q_r <= sclk_i;
            cs_q_r <= chip_select_n_i;
        end
    end

    // shift in bits; extra bits past the frame are dropped
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_r <= 5'h00;
            shift_r <= 24'h000000;
        end else if (chip_select_n_i) begin
            bit_cnt_r <= 5'h00;
        end else if (take_w) begin
            bit_cnt_r <= bit_cnt_r + vlt_pkg::ONE_BIT;
            shift_r <= {shift_r[22:0], mosi_i};
        end
    end

    // register update only at deselect, and only for a complete frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_stb_r <= 1'b0;
            op_r <= 8'h00;
            data_r <= 16'h0000;
        end else begin
            wr_stb_r <= cs_end_w & (bit_cnt_r == FRAME_BITS_L); // R1 R24
            if (cs_end_w & (bit_cnt_r == FRAME_BITS_L)) begin
                op_r <= shift_r[23:16];
                data_r <= shift_r[15:0];
            end
        end
    end

    assign wr_stb_o = wr_stb_r;
    assign wr_op_o = op_r;
    assign wr_data_o = data_r;

    property p_short_frame;
        @(posedge core_clk_i) disable iff (rst_i)
            (cs_end_w && bit_cnt_r != FRAME_BITS_L) |=> !wr_stb_o;
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame wrote"); // R24

    property p_full_frame;
        @(posedge core_clk_i) disable iff (rst_i)
            (cs_end_w && bit_cnt_r == FRAME_BITS_L) |=>
                wr_stb_o && wr_data_o == $past(shift_r[15:0]);
    endproperty
    a_full_frame: assert property (p_full_frame) else $error("full frame not taken"); // R1
endmodule : vlt_spi_rx
`default_nettype wire

// ---- sim/vlt_host_model.sv ----
/*
 * Host serial master model: frames an opcode and value, msb first.
 * Assumes the caller enters send just after a core clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module vlt_host_model (
    input wire logic clk_i, // core clock
    output logic cs_n_o, // chip_select_n, idles high
    output logic sclk_o, // serial clock, still outside frames
    output logic mosi_o // serial data
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // sends the n leading bits of w; n below 24 makes a cut frame
    task automatic send(input logic [23:0] w, input int n);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            @(posedge clk_i);
            mosi_o <= w[i];
            repeat (2) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o; // released line must not keep its value
    endtask : send
endmodule : vlt_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for the configuration block: serial writes, then
 * port checks. Assumes the host model file is compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0; // 100 MHz core clock
    logic rst = 1'b1; // reset, held 20 cycles
    logic fs = 1'b0; // frame start pulse
    logic gen = 1'b0, prd = 1'b0, lk = 1'b0; // generation on, run done, raw lock
    logic [19:0] li = 20'h00400; // line index, above a base of 200h bits
    logic [3:0] su = 4'h5; // memory u value
    wire cs_n, sclk, mosi; // serial lines from host model
    logic sel, dir, csel, pen, busy, lock; // watched outputs
    logic syn, ls, nrm, act, uvs, tk; // line, skip and converter outputs
    logic [3:0] gp, uo, vo; // pin drive, chroma
    logic [15:0] ia; // index address
    logic [16:0] da; // converter buffer address
    int n, s, a; // line length, sync and active cycle counts
    int error_cnt = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    vlt_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));
    vlt_video_line_timing_config DUT (.core_clk_i(clk), .rst_i(rst),
        .chip_select_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
        .video_generation_on_i(gen), .frame_start_i(fs), .line_index_i(li),
        .prog_run_done_i(prd), .sram_u_i(su), .sram_v_i(4'h0),
        .u_table_i(16'h0000), .v_table_i(16'h0000), .pll_lock_i(lk),
        .ctrl_nibble_i(4'hA), .sync_o(syn), .line_start_o(ls), .line_is_normal_o(nrm),
        .normal_active_o(act), .index_addr_o(ia), .ctrl_out_to_pins_select_o(sel),
        .general_purpose_pin_o(gp), .direct_converter_mode_o(dir),
        .video_clock_source_select_o(csel), .multiplier_osc_enable_o(pen),
        .lock_check_busy_o(busy), .pll_locked_o(lock), .uv_skip_o(uvs), .u_o(uo), .v_o(vo),
        .dac_tick_o(tk), .dac_buf_addr_o(da));
    // compares one value, counts it and reports a mismatch
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // full write, then three edges, one more than the register needs to show it
    task automatic wr(input logic [7:0] op, input logic [15:0] val);
        host.send({op, val}, 24);
        repeat (3) @(posedge clk);
        #1;
    endtask : wr
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // a wait that ran out counts as a mismatch and ends the run
    task automatic bail(input string m);
        error_cnt++;
        $display("CHECK FAILED %0t %s", $time, m);
        finish_test();
    endtask : bail
    // lock check lasts about 1000 cycles
    task automatic wait_idle();
        for (int i = 0; i < 1100 && busy === 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) bail("lock check hang");
    endtask : wait_idle
    // skips the current cycle, then counts one whole line from its start
    task automatic meas(output int nl, output int ns, output int na);
        nl = 0;
        ns = 0;
        na = 0;
        @(posedge clk);
        #1;
        for (int t = 0; t < 100 && ls !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        if (ls !== 1'b1) bail("no line start");
        do begin
            nl++;
            ns += int'(syn);
            na += int'(act);
            @(posedge clk);
            #1;
        end while (ls !== 1'b1 && nl < 100);
    endtask : meas
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({sel, dir, csel, pen, busy, lock, gp, ia}, 24'h000000);
        wr(vlt_pkg::OP_LINE_LEN, 16'h802A);
        chk({sel, gp}, 5'h1A);
        // cut frame: its last 16 bits would read as a length write of zero
        host.send(24'h000000, 16);
        repeat (3) @(posedge clk);
        #1;
        chk(sel, 1'b1);
        wr(vlt_pkg::OP_CTRL_ONE, 16'h1000);
        wait_idle();
        chk({busy, lock}, 2'h0);
        @(posedge clk);
        lk <= 1'b1;
        wr(vlt_pkg::OP_CTRL_ONE, 16'h1000);
        chk(busy, 1'b1);
        wait_idle();
        chk({busy, lock}, 2'h1);
        wr(vlt_pkg::OP_CTRL_ONE, 16'h3002);
        chk({dir, csel, pen, busy}, 4'h7);
        wr(vlt_pkg::OP_PIC_START, 16'hF002);
        wr(vlt_pkg::OP_PIC_END, 16'hF004);
        wr(vlt_pkg::OP_INDEX_BASE, 16'h0010);
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        @(posedge clk);
        #1;
        chk(ia, 16'h0040);
        @(posedge clk);
        gen <= 1'b1;
        meas(n, s, a);
        chk({n[7:0], s[7:0], a[7:0]}, 24'h340A10);
        chk({nrm, ia}, 17'h10046);
        @(posedge clk);
        li <= 20'h001FF; // one bit below the base: protoline
        meas(n, s, a);
        chk({n[7:0], a[7:0], nrm}, 17'h06800);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            prd <= 1'b1;
            @(posedge clk);
            prd <= 1'b0;
            #1;
            chk(uvs, k < 2);
        end
        chk({uo, vo}, 8'h50);
        wr(vlt_pkg::OP_CTRL_ONE, 16'h9000);
        chk({dir, csel, pen, lock, syn, ls, act}, 7'h50);
        for (int t = 0; t < 20 && tk !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        if (tk !== 1'b1) bail("no converter tick");
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tk !== 1'b1 && n < 20);
        chk(n[7:0], 8'h08);
        chk(da, 17'h00021);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
